// ---- common/fsg_pkg.sv ----
// Package for the frame sync generator: register map, fields, carriers.
// Assumes a 32-bit APB master and one core clock pclk.
package fsg_pkg;
  localparam logic [7:0] OFF_A_CTL0 = 8'h00;
  localparam logic [7:0] OFF_A_CTL1 = 8'h04;
  localparam logic [7:0] OFF_B_CTL0 = 8'h08;
  localparam logic [7:0] OFF_B_CTL1 = 8'h0c;
  localparam logic [7:0] OFF_PW     = 8'h10;
  localparam logic [7:0] OFF_SYNC   = 8'h14;
  localparam logic [7:0] OFF_STAT   = 8'h18;
  localparam logic [31:0] RST_VAL   = 32'h0000_0000;
  localparam int DIV_LSB   = 0;
  localparam int DIV_W     = 20;
  localparam int PH_LSB    = 20;
  localparam int PH_HALF_W = 10;
  localparam int CLK_EN_B  = 31;
  localparam int FS_EN_B   = 30;
  localparam int SRC_B     = 30;
  localparam int PW_W      = 16;
  localparam int UNIT_B_SH = 16;
  localparam int STROBE_B  = 0;
  localparam int INV_B     = 1;
  localparam int TRIG_FS_B = 0;
  localparam int TRIG_CK_B = 1;
  localparam logic [19:0] BYPASS_MAX = 20'h00001;

  typedef struct packed {
    logic        fs_en;
    logic        src_sel;
    logic [19:0] div;
    logic [19:0] phase;
    logic [15:0] width;
    logic        one_shot;
    logic        invert;
    logic        trig_fs;
    logic        trig_clk;
  } fsg_cfg_t;

  typedef struct packed {
    logic crystal;
    logic ext_src;
    logic strobe;
    logic trigger;
  } fsg_in_t;
endpackage

// ---- src/fsg_top.sv ----
// Frame sync generator, two units, APB register file and unit logic.
// Inputs are synchronous samples of the clocks in the pclk domain.
// How it works
// - Divisor 0 or 1 selects bypass; larger values select divided mode.
// - Normal mode period equals the 20-bit divisor in source cycles.
// - Each unit enabled alone; source is crystal or its external input.
// - Bit 30 of second control register picks source; set selects external.
// - High time equals 16-bit width field, A low half, B high half.
// - Zero width gives half divisor, odd divisors rounded down.
// - Phase is 20 bits: upper from first, lower from second register.
// - Zero phase with matching setup makes clock and sync rise together.
// - Sync transition follows the clock start by phase source periods.
// - On enable counter starts as if divisor minus phase elapsed.
// - Pass-through bypass copies source, inverted when invert bit set.
// - One-shot bypass emits one strobe period each source period.
// - One-shot starts at second strobe rise after source edge.
// - Invert gives low pulse in low phase, else high in high.
// - Width bits above the two mode bits ignored in bypass.
// - Trigger enable holds the sync off until trigger rises.
// - Clock sync enable starts clock output on trigger rise.
// - Top bit of first control is clock enable, next is sync enable.
`timescale 1ns/10ps
`default_nettype none

module fsg_unit
  import fsg_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire fsg_cfg_t cfg,
  input  wire logic     clk_en,
  input  wire fsg_in_t  pins,
  output logic          fs_out,
  output logic          clk_go
);
  typedef enum logic [1:0] {FSG_OFF, FSG_WAIT, FSG_RUN} fsg_st_t;
  fsg_st_t st_q, st_d;
  logic src_q, stb_q, trg_q;
  logic [19:0] cnt_q, cnt_d;
  logic [1:0]  sc_q, sc_d;
  logic        os_q, os_d;
  logic        fs_d;
  logic        clk_go_d;
  wire src = cfg.src_sel ? pins.ext_src : pins.crystal;
  wire src_rise = src & ~src_q;
  wire src_fall = ~src & src_q;
  wire stb_rise = pins.strobe & ~stb_q;
  wire trg_rise = pins.trigger & ~trg_q;
  wire bypass = (cfg.div <= BYPASS_MAX);
  wire [19:0] half = {1'b0, cfg.div[19:1]};
  wire [19:0] hi_t = (cfg.width == 16'h0000) ? half : {4'h0, cfg.width};
  wire [19:0] pre = cfg.div - cfg.phase;
  wire [19:0] nxt = (cnt_q + 20'h00001 >= cfg.div) ? 20'h00000
                  : cnt_q + 20'h00001;
  wire arm_edge = cfg.invert ? src_fall : src_rise;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sc_d = sc_q;
    os_d = os_q;
    fs_d = 1'b0;
    clk_go_d = clk_go;
    if (!clk_en)
      clk_go_d = 1'b0;
    else if (!cfg.trig_clk || trg_rise)
      clk_go_d = 1'b1;
    unique case (st_q)
      FSG_OFF: begin
        if (cfg.fs_en)
          st_d = cfg.trig_fs ? FSG_WAIT : FSG_RUN;
        cnt_d = (pre >= cfg.div) ? 20'h00000 : pre;
        sc_d = 2'd0;
        os_d = 1'b0;
      end
      FSG_WAIT: begin
        if (trg_rise)
          st_d = FSG_RUN;
      end
      FSG_RUN: begin
        if (src_rise)
          cnt_d = nxt;
        if (!bypass)
          fs_d = (cnt_d < hi_t);
        else if (!cfg.one_shot)
          fs_d = src ^ cfg.invert;
        else begin
          if (arm_edge) begin
            // Inverted: a coincident strobe rise counts as the first
            sc_d = (cfg.invert && stb_rise) ? 2'd1 : 2'd0;
            os_d = 1'b0;
          end else if (stb_rise && sc_q != 2'd3) begin
            sc_d = sc_q + 2'd1;
            os_d = (sc_q == 2'd1);
          end
          fs_d = os_d ^ cfg.invert;
        end
      end
      default: st_d = FSG_OFF;
    endcase
    if (!cfg.fs_en) begin
      st_d = FSG_OFF;
      fs_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= FSG_OFF;
      cnt_q <= 20'h00000;
      sc_q <= 2'd0;
      os_q <= 1'b0;
      src_q <= 1'b0;
      stb_q <= 1'b0;
      trg_q <= 1'b0;
      fs_out <= 1'b0;
      clk_go <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sc_q <= sc_d;
      os_q <= os_d;
      src_q <= src;
      stb_q <= pins.strobe;
      trg_q <= pins.trigger;
      fs_out <= fs_d;
      clk_go <= clk_go_d;
    end
  end

  // Properties share the core clock and the bus reset
  default clocking u_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Pass-through running
  sequence s_pass_mode;
    st_q == FSG_RUN && cfg.fs_en && bypass && !cfg.one_shot;
  endsequence
  // One-shot running
  sequence s_shot_mode;
    st_q == FSG_RUN && cfg.fs_en && bypass && cfg.one_shot;
  endsequence
  // Source edge re-arms the one-shot
  sequence s_shot_armed;
    s_shot_mode ##0 arm_edge;
  endsequence
  // Pulse up and the strobe rises again
  sequence s_shot_ends;
    s_shot_mode ##0 (os_q && stb_rise);
  endsequence
  // Held off, no trigger edge yet
  sequence s_trig_wait;
    st_q == FSG_WAIT && cfg.fs_en && !trg_rise;
  endsequence
  // Held off, trigger edge now
  sequence s_trig_seen;
    st_q == FSG_WAIT && cfg.fs_en && trg_rise;
  endsequence

  a_zero_phase_start: assert property (
    st_q == FSG_OFF && cfg.fs_en && !cfg.trig_fs && cfg.phase == 20'h0
    && !bypass |=> cnt_q == 20'h0)
    else $error("zero phase must start count at zero");
  a_trigger_hold: assert property (
    st_q == FSG_WAIT |=> !fs_out)
    else $error("frame sync active while awaiting trigger");
  a_trigger_waits: assert property (
    s_trig_wait |=> st_q == FSG_WAIT)
    else $error("left trigger wait without a trigger edge");
  a_trigger_start: assert property (
    s_trig_seen |=> st_q == FSG_RUN)
    else $error("trigger edge did not start generation");
  a_disabled_low: assert property (
    !cfg.fs_en |=> !fs_out)
    else $error("frame sync high while disabled");
  a_pass_through: assert property (
    s_pass_mode |=> fs_out == ($past(src) ^ $past(cfg.invert)))
    else $error("pass-through output mismatch");
  a_clock_trigger: assert property (
    !clk_go && clk_en && cfg.trig_clk && !trg_rise |=> !clk_go)
    else $error("clock started without trigger");
  a_clock_free: assert property (
    clk_en && !cfg.trig_clk |=> clk_go)
    else $error("clock not started without trigger mode");
  a_clock_gate: assert property (
    !clk_en |=> !clk_go)
    else $error("clock running while its enable is clear");
  a_count_bound: assert property (
    st_q == FSG_RUN && !bypass && $stable(cfg) |-> cnt_q < cfg.div)
    else $error("counter beyond divisor");
  a_width_high: assert property (
    st_q == FSG_RUN && cfg.fs_en && !bypass
    |=> fs_out == ($past(cnt_d) < $past(hi_t)))
    else $error("normal mode high time wrong");
  a_default_width: assert property (
    cfg.width == 16'h0000
    |-> hi_t + hi_t + {19'h00000, cfg.div[0]} == cfg.div)
    else $error("default high time is not half the divisor");
  a_enable_preload: assert property (
    st_q == FSG_OFF && cfg.phase < cfg.div && cfg.phase != 20'h0
    |=> cnt_q == $past(pre))
    else $error("enable preload wrong");
  a_shot_rearm: assert property (
    s_shot_armed |=> fs_out == $past(cfg.invert))
    else $error("one-shot not idle after source edge");
  a_shot_one_period: assert property (
    s_shot_ends |=> !os_q)
    else $error("one-shot longer than a strobe period");
endmodule // fsg_unit

module fsg_top
  import fsg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystal_clock_in,
  input  wire logic        ext_src_a,
  input  wire logic        ext_src_b,
  input  wire logic        strobe_width_in_a,
  input  wire logic        strobe_width_in_b,
  input  wire logic        external_trigger_in_a,
  input  wire logic        external_trigger_in_b,
  output logic             frame_sync_a,
  output logic             frame_sync_b,
  output logic             clock_enable_a,
  output logic             clock_enable_b
);
  logic [31:0] a0_q, a1_q, b0_q, b1_q, pw_q, sy_q;
  fsg_cfg_t cfg_a, cfg_b;
  fsg_in_t  in_a, in_b;
  logic fs_a, fs_b, go_a, go_b;

  wire setup  = psel & ~penable;
  wire wr     = psel & penable & pwrite;
  wire hit_a0 = paddr == OFF_A_CTL0;
  wire hit_a1 = paddr == OFF_A_CTL1;
  wire hit_b0 = paddr == OFF_B_CTL0;
  wire hit_b1 = paddr == OFF_B_CTL1;
  wire hit_pw = paddr == OFF_PW;
  wire hit_sy = paddr == OFF_SYNC;
  wire hit_st = paddr == OFF_STAT;
  wire mapped = hit_a0 | hit_a1 | hit_b0 | hit_b1 | hit_pw | hit_sy
              | hit_st;
  wire [31:0] rd_mux =
      hit_a0 ? a0_q : hit_a1 ? a1_q : hit_b0 ? b0_q : hit_b1 ? b1_q :
      hit_pw ? pw_q : hit_sy ? sy_q :
      hit_st ? {28'h0, go_b, go_a, fs_b, fs_a} : 32'h0;

  assign cfg_a = '{fs_en: a0_q[FS_EN_B], src_sel: a1_q[SRC_B],
    div: a0_q[DIV_LSB +: DIV_W],
    phase: {a0_q[PH_LSB +: PH_HALF_W], a1_q[PH_LSB +: PH_HALF_W]},
    width: pw_q[0 +: PW_W], one_shot: pw_q[STROBE_B],
    invert: pw_q[INV_B], trig_fs: sy_q[TRIG_FS_B],
    trig_clk: sy_q[TRIG_CK_B]};
  assign cfg_b = '{fs_en: b0_q[FS_EN_B], src_sel: b1_q[SRC_B],
    div: b0_q[DIV_LSB +: DIV_W],
    phase: {b0_q[PH_LSB +: PH_HALF_W], b1_q[PH_LSB +: PH_HALF_W]},
    width: pw_q[UNIT_B_SH +: PW_W], one_shot: pw_q[UNIT_B_SH + STROBE_B],
    invert: pw_q[UNIT_B_SH + INV_B], trig_fs: sy_q[UNIT_B_SH + TRIG_FS_B],
    trig_clk: sy_q[UNIT_B_SH + TRIG_CK_B]};
  assign in_a = '{crystal: crystal_clock_in, ext_src: ext_src_a,
    strobe: strobe_width_in_a, trigger: external_trigger_in_a};
  assign in_b = '{crystal: crystal_clock_in, ext_src: ext_src_b,
    strobe: strobe_width_in_b, trigger: external_trigger_in_b};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a0_q <= RST_VAL;
      a1_q <= RST_VAL;
      b0_q <= RST_VAL;
      b1_q <= RST_VAL;
      pw_q <= RST_VAL;
      sy_q <= RST_VAL;
      prdata <= RST_VAL;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // No wait state: answer registered in setup, given in first access cycle
      pready <= setup;
      pslverr <= setup & ~(mapped & ~(pwrite & hit_st));
      prdata <= (setup & ~pwrite) ? rd_mux : RST_VAL;
      if (wr && pready) begin
        if (hit_a0) a0_q <= pwdata;
        if (hit_a1) a1_q <= pwdata;
        if (hit_b0) b0_q <= pwdata;
        if (hit_b1) b1_q <= pwdata;
        if (hit_pw) pw_q <= pwdata;
        if (hit_sy) sy_q <= pwdata;
      end
    end
  end

  fsg_unit u_a (.pclk(pclk), .presetn(presetn), .cfg(cfg_a),
    .clk_en(a0_q[CLK_EN_B]), .pins(in_a), .fs_out(fs_a), .clk_go(go_a));
  fsg_unit u_b (.pclk(pclk), .presetn(presetn), .cfg(cfg_b),
    .clk_en(b0_q[CLK_EN_B]), .pins(in_b), .fs_out(fs_b), .clk_go(go_b));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_a <= 1'b0;
      frame_sync_b <= 1'b0;
      clock_enable_a <= 1'b0;
      clock_enable_b <= 1'b0;
    end else begin
      frame_sync_a <= fs_a;
      frame_sync_b <= fs_b;
      clock_enable_a <= go_a;
      clock_enable_b <= go_b;
    end
  end

  // Bus-side properties on the same clock
  default clocking t_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ctl_write: assert property (
    wr && pready && hit_a0 |=> a0_q[FS_EN_B] == $past(pwdata[FS_EN_B]))
    else $error("control write did not land");
  a_sync_off_a: assert property (
    !a0_q[FS_EN_B] |=> ##1 !frame_sync_a)
    else $error("frame sync A pin high while disabled");
  a_sync_off_b: assert property (
    !b0_q[FS_EN_B] |=> ##1 !frame_sync_b)
    else $error("frame sync B pin high while disabled");
  a_clk_off_a: assert property (
    !a0_q[CLK_EN_B] |=> ##1 !clock_enable_a)
    else $error("clock A pin high while disabled");
endmodule // fsg_top
`default_nettype wire

// ---- testbench/fsg_peer.sv ----
// Frame sync receiver: makes the crystal source, times frame sync A.
// Assumes the pclk domain; the crystal toggles every 2 pclk cycles.
`timescale 1ns/10ps
`default_nettype none
module fsg_peer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fs,
  output logic      crystal,
  output int        per,
  output int        hi,
  output int        rises,
  output int        src_rises
);
  logic [1:0] div_q;
  logic       fs_q;
  int         cnt;
  assign crystal = div_q[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      fs_q <= 1'b0;
      cnt <= 0;
      per <= 0;
      hi <= 0;
      rises <= 0;
      src_rises <= 0;
    end else begin
      div_q <= div_q + 2'h1;
      fs_q <= fs;
      cnt <= cnt + 1;
      if (div_q == 2'h1) src_rises <= src_rises + 1;
      // Counts restart at each rise, so a partial frame is dropped
      if (fs && !fs_q) begin
        per <= cnt;
        cnt <= 1;
        rises <= rises + 1;
      end
      if (!fs && fs_q) hi <= cnt;
    end
  end
endmodule // fsg_peer
`default_nettype wire

// ---- testbench/frame_sync_generator_test.sv ----
// Self-checking bench for the frame sync generator over APB.
// Assumes fsg_top and fsg_peer; one 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module frame_sync_generator_test;
  import fsg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        crys, src_b, stb, trg, fs_a, fs_b, ck_a, ck_b, err;
  int          per, hi, rises, srcr, edges, e1, error_cnt, total_checks;

  fsg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock_in(crys), .ext_src_a(src_b), .ext_src_b(src_b),
    .strobe_width_in_a(stb), .strobe_width_in_b(stb),
    .external_trigger_in_a(trg), .external_trigger_in_b(trg),
    .frame_sync_a(fs_a), .frame_sync_b(fs_b),
    .clock_enable_a(ck_a), .clock_enable_b(ck_b));
  fsg_peer u_peer (.pclk(pclk), .presetn(presetn), .fs(fs_a),
    .crystal(crys), .per(per), .hi(hi), .rises(rises), .src_rises(srcr));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #600000;
    error_cnt++;
    conclude();
  end
  always @(posedge pclk) stb <= ~stb;

  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h want %h", $time, s, e);
    end
  endtask

  // Setup, then access held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_rises(input int k);
    int t0;
    int n;
    t0 = rises;
    n = 0;
    while (rises < t0 + k && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (rises < t0 + k) begin
      error_cnt++;
      $display("mismatch at %0t: no frame", $time);
    end
  endtask

  task t_regs;
    for (int a = 0; a <= 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, RST_VAL);
    end
    apb(1'b1, OFF_PW, 32'h1234_5678);
    apb(1'b0, OFF_PW, 32'h0);
    chk(rd, 32'h1234_5678);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFF_STAT, 32'h1);
    chk({31'h0, err}, 32'h1);
    chk({30'h0, fs_a, fs_b}, 32'h0);
  endtask

  // Registers written before enable, disabled before any change
  task t_norm(input logic [19:0] dv, input logic [15:0] w,
              input int h, input logic [9:0] ph);
    int e;
    apb(1'b1, OFF_A_CTL1, {2'b00, ph, 20'h0});
    apb(1'b1, OFF_PW, {16'h0, w});
    // Fixed source phase at enable keeps the edge count exact
    @(posedge crys);
    apb(1'b1, OFF_A_CTL0, {2'b01, 10'h0, dv});
    e = srcr;
    wait_rises(1);
    edges = srcr - e;
    if (ph != 10'h0) chk(32'(edges), 32'(ph));
    wait_rises(3);
    chk(32'(per), 32'(dv) * 4);
    chk(32'(hi), 32'(h * 4));
    apb(1'b1, OFF_A_CTL0, 32'h0);
  endtask

  task t_bypass;
    apb(1'b1, OFF_B_CTL1, 32'h4000_0000);
    for (int inv = 0; inv < 2; inv++) begin
      // Junk in the ignored width bits must not matter
      apb(1'b1, OFF_PW, inv ? 32'hfffe_0000 : 32'hfffc_0000);
      apb(1'b1, OFF_B_CTL0, 32'h4000_0001);
      for (int i = 0; i < 4; i++) begin
        @(posedge pclk);
        src_b <= i[0];
        repeat (6) @(posedge pclk);
        chk({31'h0, fs_b}, {31'h0, src_b ^ inv[0]});
      end
      apb(1'b1, OFF_B_CTL0, 32'h0);
    end
  endtask

  // One-shot on unit B: slow source, strobe every second pclk
  task t_oneshot;
    int n;
    for (int inv = 0; inv < 2; inv++) begin
      apb(1'b1, OFF_PW, inv ? 32'h0003_0000 : 32'h0001_0000);
      apb(1'b1, OFF_B_CTL0, 32'h4000_0001);
      n = 0;
      for (int i = 0; i < 64; i++) begin
        @(posedge pclk);
        src_b <= i[3];
        if (i >= 32 && (fs_b ^ inv[0])) n++;
      end
      chk(32'(n), 32'h4);
      apb(1'b1, OFF_B_CTL0, 32'h0);
    end
  endtask

  task t_trig;
    int r0;
    apb(1'b1, OFF_PW, 32'h0);
    apb(1'b1, OFF_SYNC, 32'h3);
    apb(1'b1, OFF_A_CTL1, {2'b00, 10'd3, 20'h0});
    apb(1'b1, OFF_A_CTL0, {2'b11, 10'h0, 20'd8});
    r0 = rises;
    repeat (40) @(posedge pclk);
    chk(32'(rises - r0), 32'h0);
    chk({31'h0, ck_a}, 32'h0);
    trg <= 1'b1;
    wait_rises(1);
    chk(32'(rises - r0), 32'h1);
    chk({31'h0, ck_a}, 32'h1);
    apb(1'b1, OFF_A_CTL0, 32'h0);
  endtask

  task conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, src_b, stb, trg} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_norm(20'd8, 16'd3, 3, 10'd1);
    e1 = edges;
    t_norm(20'd8, 16'd3, 3, 10'd3);
    chk(32'(edges - e1), 32'h2);
    t_norm(20'd9, 16'd0, 4, 10'd0);
    t_norm(20'd10, 16'd0, 5, 10'd0);
    t_norm(20'd2, 16'd1, 1, 10'd0);
    t_bypass();
    t_oneshot();
    t_trig();
    conclude();
  end
endmodule // frame_sync_generator_test
`default_nettype wire
